/* File: verilog/asr_top.v */
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "asr_consts.vh"
// Analog speed reference conditioning with AHB-Lite register access
module asr_top #(
    parameter SAMPLE_CYCLES = `ASR_SAMPLE_US * `ASR_CLK_MHZ,
    parameter TICK_W = 18
) (
    clock,
    nrst,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    volt_in,
    cur_in,
    pot_in,
    channel_switch_input,
    freq_cmd,
    volt_cmd,
    cmd_active
);
    input wire clock;
    input wire nrst;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg [31:0] hrdata;
    output reg hreadyout;
    output reg hresp;
    input wire [11:0] volt_in;
    input wire [11:0] cur_in;
    input wire [11:0] pot_in;
    input wire channel_switch_input;
    output reg [15:0] freq_cmd;
    output reg [15:0] volt_cmd;
    output reg cmd_active;

    localparam S_IDLE = 2'd0;
    localparam S_IIR = 2'd1;
    localparam S_UPD = 2'd2;
    localparam S_OUT = 2'd3;
    localparam TAU_I = `ASR_TAU_SAMPLES;
    localparam signed [24:0] TAU_S = TAU_I[24:0];

    // Linear span mapping with below-start and end saturation
    function [15:0] asr_map;
        input [11:0] code;
        input [17:0] pct;
        input [31:0] fr;
        reg [18:0] x;
        reg [18:0] lo;
        reg [18:0] hi;
        reg signed [37:0] num;
        reg signed [37:0] q;
        begin
            x = {7'h00, code} * {12'h000, `ASR_PCT_FULL};
            lo = {12'h000, pct[`ASR_PCT_START]} * {7'h00, `ASR_ADC_FULL};
            hi = {12'h000, pct[`ASR_PCT_END]} * {7'h00, `ASR_ADC_FULL};
            num = 38'sh0;
            q = 38'sh0;
            if (x < lo) begin
                // Below the active span
                asr_map = (pct[`ASR_PCT_EN] == `ASR_EN_USE_START) ? fr[`ASR_FR_START] : 16'h0000;
            end else if (x >= hi) begin
                // Past the end: no extrapolation
                asr_map = fr[`ASR_FR_END];
            end else begin
                num = ($signed({22'h0, fr[`ASR_FR_END]}) - $signed({22'h0, fr[`ASR_FR_START]}))
                    * $signed({19'h0, x - lo});
                q = num / $signed({19'h0, hi - lo});
                asr_map = fr[`ASR_FR_START] + q[15:0];
            end
        end
    endfunction

    // Bus and configuration state
    reg [12:0] ctrl_reg;
    reg [31:0] motor1_reg;
    reg [31:0] motor2_reg;
    reg [31:0] vfreq_reg;
    reg [17:0] vpct_reg;
    reg [31:0] cfreq_reg;
    reg [17:0] cpct_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    // Input synchronisers
    reg [36:0] in_s1_reg;
    reg [36:0] in_s2_reg;
    // Sampling and filter state
    reg [TICK_W-1:0] tick_cnt_reg;
    reg [1:0] state_reg;
    reg [15:0] ch_ref_reg;
    reg [15:0] samp_reg;
    reg [23:0] iir_reg;
    reg [20:0] sum_reg;
    reg [4:0] wp_reg;
    reg [4:0] cnt_reg;
    reg [4:0] n_prev_reg;
    reg [3:0] blk_reg;
    reg [15:0] point_reg;
    reg [15:0] filt_reg;

    wire [11:0] volt_s = in_s2_reg[11:0];
    wire [11:0] cur_s = in_s2_reg[23:12];
    wire [11:0] pot_s = in_s2_reg[35:24];
    wire sw_s = in_s2_reg[36];
    wire db_mode = (ctrl_reg[`ASR_CTRL_FILT] == `ASR_FILT_DEADBAND);
    wire [4:0] n_set = (ctrl_reg[`ASR_CTRL_FILT] == 5'h00) ? 5'h01 : ctrl_reg[`ASR_CTRL_FILT];
    wire [4:0] n_eff = db_mode ? `ASR_DB_SAMPLES : n_set;
    wire [15:0] mem_rdata;

    // Active motor set and its limits
    wire [31:0] motor_w = ctrl_reg[`ASR_CTRL_MOTOR] ? motor2_reg : motor1_reg;
    reg [15:0] max_eff;
    reg [15:0] base_eff;
    always @* begin
        // Maximum held between the lowest base and 400 Hz
        max_eff = motor_w[`ASR_MOT_MAX];
        if (max_eff > `ASR_FREQ_MAX) begin
            max_eff = `ASR_FREQ_MAX;
        end else if (max_eff < `ASR_FREQ_MIN_BASE) begin
            max_eff = `ASR_FREQ_MIN_BASE;
        end
        // Base held between 30 Hz and the maximum
        base_eff = motor_w[`ASR_MOT_BASE];
        if (base_eff < `ASR_FREQ_MIN_BASE) begin
            base_eff = `ASR_FREQ_MIN_BASE;
        end else if (base_eff > max_eff) begin
            base_eff = max_eff;
        end
    end

    // Channel conversion and selection
    wire [15:0] v_ref = asr_map(volt_s, vpct_reg, vfreq_reg);
    wire [15:0] c_ref = asr_map(cur_s, cpct_reg, cfreq_reg);
    wire [27:0] pot_prod = {16'h0000, pot_s} * {12'h000, max_eff};
    wire [27:0] pot_q = pot_prod / {16'h0000, `ASR_ADC_FULL};
    wire [16:0] vc_sum = {1'b0, v_ref} + {1'b0, c_ref};
    reg [15:0] sel_ref;
    always @* begin
        if (!ctrl_reg[`ASR_CTRL_SWASG]) begin
            // No switch terminal: sum of both, held at 400 Hz
            sel_ref = (vc_sum > {1'b0, `ASR_FREQ_MAX}) ? `ASR_FREQ_MAX : vc_sum[15:0];
        end else if (ctrl_reg[`ASR_CTRL_SWSEL] == `ASR_SW_POT_VOLT) begin
            sel_ref = sw_s ? pot_q[15:0] : v_ref;
        end else if (ctrl_reg[`ASR_CTRL_SWSEL] == `ASR_SW_POT_CUR) begin
            sel_ref = sw_s ? pot_q[15:0] : c_ref;
        end else begin
            // Code 00, and the undefined 01, pick current or voltage
            sel_ref = sw_s ? c_ref : v_ref;
        end
    end

    // First-order smoothing for deadband mode, 8 fraction bits
    wire signed [24:0] iir_diff = $signed({1'b0, ch_ref_reg, 8'h00}) - $signed({1'b0, iir_reg});
    wire signed [24:0] iir_step = iir_diff / TAU_S;
    wire [24:0] iir_sum = {1'b0, iir_reg} + iir_step;
    wire [23:0] iir_next = iir_sum[23:0];

    // Average and deadband helpers
    wire [20:0] avg_w = sum_reg / {16'h0000, n_eff};
    wire [15:0] avg16 = avg_w[15:0];
    wire [15:0] db_diff = (avg16 > point_reg) ? avg16 - point_reg : point_reg - avg16;
    wire [15:0] filt_lim = (filt_reg > max_eff) ? max_eff : filt_reg;
    wire [31:0] vprod = {16'h0000, freq_cmd} * {16'h0000, `ASR_VOLT_FULL};
    wire [31:0] vq = vprod / {16'h0000, base_eff};

    // History buffer, oldest sample read n places behind the write pointer
    asr_sample_mem #(
        .WIDTH(16),
        .AW(5)
    ) u_mem (
        .clock(clock),
        .wr_en(state_reg == S_UPD),
        .wr_addr(wp_reg),
        .wr_data(samp_reg),
        .rd_addr(wp_reg - n_eff),
        .rd_data(mem_rdata)
    );

    // Pins are asynchronous to the clock; each passes two flops
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            in_s1_reg <= 37'h0;
            in_s2_reg <= 37'h0;
        end else begin
            in_s1_reg <= {channel_switch_input, pot_in, cur_in, volt_in};
            in_s2_reg <= in_s1_reg;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            ctrl_reg <= `ASR_CTRL_RST;
            motor1_reg <= `ASR_MOT_RST;
            motor2_reg <= `ASR_MOT_RST;
            vfreq_reg <= `ASR_FR_RST;
            vpct_reg <= `ASR_PCT_RST;
            cfreq_reg <= `ASR_FR_RST;
            cpct_reg <= `ASR_PCT_RST;
        end else begin
            // Data phase of a write stores into the captured address
            if (wr_pend_reg) begin
                if (wr_addr_reg == `ASR_OFS_CTRL) begin
                    ctrl_reg <= hwdata[12:0];
                end else if (wr_addr_reg == `ASR_OFS_MOTOR1) begin
                    motor1_reg <= hwdata;
                end else if (wr_addr_reg == `ASR_OFS_MOTOR2) begin
                    motor2_reg <= hwdata;
                end else if (wr_addr_reg == `ASR_OFS_VFREQ) begin
                    vfreq_reg <= hwdata;
                end else if (wr_addr_reg == `ASR_OFS_VPCT) begin
                    vpct_reg <= hwdata[17:0] & `ASR_PCT_MASK;
                end else if (wr_addr_reg == `ASR_OFS_CFREQ) begin
                    cfreq_reg <= hwdata;
                end else if (wr_addr_reg == `ASR_OFS_CPCT) begin
                    cpct_reg <= hwdata[17:0] & `ASR_PCT_MASK;
                end
            end
            // Address phase: latch writes, prepare read data for next cycle
            wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite) begin
                if (haddr[7:0] == `ASR_OFS_CTRL) begin
                    hrdata <= {19'h0, ctrl_reg};
                end else if (haddr[7:0] == `ASR_OFS_MOTOR1) begin
                    hrdata <= motor1_reg;
                end else if (haddr[7:0] == `ASR_OFS_MOTOR2) begin
                    hrdata <= motor2_reg;
                end else if (haddr[7:0] == `ASR_OFS_VFREQ) begin
                    hrdata <= vfreq_reg;
                end else if (haddr[7:0] == `ASR_OFS_VPCT) begin
                    hrdata <= {14'h0, vpct_reg};
                end else if (haddr[7:0] == `ASR_OFS_CFREQ) begin
                    hrdata <= cfreq_reg;
                end else if (haddr[7:0] == `ASR_OFS_CPCT) begin
                    hrdata <= {14'h0, cpct_reg};
                end else if (haddr[7:0] == `ASR_OFS_STATUS) begin
                    hrdata <= {14'h0, db_mode, cmd_active, freq_cmd};
                end else if (haddr[7:0] == `ASR_OFS_VOUT) begin
                    hrdata <= {16'h0, volt_cmd};
                end else begin
                    // Unmapped reads give zero
                    hrdata <= 32'h0;
                end
            end
        end
    end

    // Sample sequencer: one pass per 2 ms tick
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_reg <= {TICK_W{1'b0}};
            state_reg <= S_IDLE;
            ch_ref_reg <= 16'h0000;
            samp_reg <= 16'h0000;
            iir_reg <= 24'h000000;
            sum_reg <= 21'h0;
            wp_reg <= 5'h00;
            cnt_reg <= 5'h00;
            n_prev_reg <= 5'h00;
            blk_reg <= 4'h0;
            point_reg <= 16'h0000;
            filt_reg <= 16'h0000;
        end else begin
            if (tick_cnt_reg == SAMPLE_CYCLES[TICK_W-1:0] - 1'b1) begin
                tick_cnt_reg <= {TICK_W{1'b0}};
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 1'b1;
            end
            case (state_reg)
                S_IDLE: begin
                    // Capture the converted, selected channel on the tick
                    if (tick_cnt_reg == {TICK_W{1'b0}}) begin
                        ch_ref_reg <= sel_ref;
                        state_reg <= S_IIR;
                    end
                end
                S_IIR: begin
                    // Deadband mode smooths before averaging
                    if (db_mode) begin
                        iir_reg <= iir_next;
                        samp_reg <= iir_next[23:8];
                    end else begin
                        iir_reg <= {ch_ref_reg, 8'h00};
                        samp_reg <= ch_ref_reg;
                    end
                    state_reg <= S_UPD;
                end
                S_UPD: begin
                    // Running sum; restart the window when its length changes
                    if (n_eff != n_prev_reg) begin
                        sum_reg <= {5'h00, samp_reg};
                        cnt_reg <= 5'h01;
                        blk_reg <= 4'h1;
                        n_prev_reg <= n_eff;
                    end else begin
                        if (cnt_reg >= n_eff) begin
                            sum_reg <= sum_reg + {5'h00, samp_reg} - {5'h00, mem_rdata};
                        end else begin
                            sum_reg <= sum_reg + {5'h00, samp_reg};
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                        blk_reg <= blk_reg + 1'b1;
                    end
                    wp_reg <= wp_reg + 1'b1;
                    state_reg <= S_OUT;
                end
                default: begin
                    if (!db_mode) begin
                        filt_reg <= avg16;
                    end else if (blk_reg == 4'h0 && cnt_reg >= n_eff) begin
                        // Every fresh 16-sample block is checked against the point
                        if (db_diff >= `ASR_DEADBAND) begin
                            point_reg <= avg16;
                            filt_reg <= avg16;
                        end
                    end
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Command and V/f voltage outputs, refreshed every clock
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            freq_cmd <= 16'h0000;
            volt_cmd <= 16'h0000;
            cmd_active <= 1'b0;
        end else begin
            // Only the control-terminal source drives the command
            cmd_active <= (ctrl_reg[`ASR_CTRL_SRC] == `ASR_SRC_TERMINAL);
            freq_cmd <= (ctrl_reg[`ASR_CTRL_SRC] == `ASR_SRC_TERMINAL) ? filt_lim : 16'h0000;
            // Proportional below base, full scale from base to max
            if (freq_cmd >= base_eff) begin
                volt_cmd <= `ASR_VOLT_FULL;
            end else begin
                volt_cmd <= vq[15:0];
            end
        end
    end
endmodule

/* File: verilog/asr_consts.vh */
// Summary of operation
// - Base frequency 30 Hz to max, default 60.0
// - Maximum frequency from base up to 400 Hz
// - Voltage rises with frequency until base, then flat
// - Two motor parameter sets, active one used
// - Voltage channel maps percent span onto frequency span
// - Below start: start frequency (00) or zero (01)
// - Above end percent saturate at end frequency
// - Current channel uses same mapping, own settings
// - Channel switch code picks voltage, current or pot
// - No switch terminal assigned: use voltage plus current
// - Setting 1-30: moving average, 2 ms per step
// - Setting 31: 500 ms filter, 0.1 Hz deadband
// - Average past deadband becomes reference and comparison point
// - Analog command only when source code is 01
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
// Register byte offsets
`define ASR_OFS_CTRL 8'h00
`define ASR_OFS_MOTOR1 8'h04
`define ASR_OFS_MOTOR2 8'h08
`define ASR_OFS_VFREQ 8'h0c
`define ASR_OFS_VPCT 8'h10
`define ASR_OFS_CFREQ 8'h14
`define ASR_OFS_CPCT 8'h18
`define ASR_OFS_STATUS 8'h1c
`define ASR_OFS_VOUT 8'h20
// Control register fields
`define ASR_CTRL_SRC 3:0
`define ASR_CTRL_SWSEL 5:4
`define ASR_CTRL_SWASG 6
`define ASR_CTRL_MOTOR 7
`define ASR_CTRL_FILT 12:8
`define ASR_CTRL_RST 13'h0842
// Motor word: base low half, max high half, 0.01 Hz units
`define ASR_MOT_BASE 15:0
`define ASR_MOT_MAX 31:16
`define ASR_MOT_RST 32'h1770_1770
// Frequency span word: start low, end high
`define ASR_FR_START 15:0
`define ASR_FR_END 31:16
`define ASR_FR_RST 32'h0000_0000
// Percent span word
`define ASR_PCT_START 6:0
`define ASR_PCT_END 14:8
`define ASR_PCT_EN 17:16
`define ASR_PCT_MASK 18'h37f7f
`define ASR_PCT_RST 18'h16400
// Codes and limits
`define ASR_SRC_TERMINAL 4'h1
`define ASR_SW_POT_VOLT 2'h2
`define ASR_SW_POT_CUR 2'h3
`define ASR_EN_USE_START 2'h0
`define ASR_FILT_DEADBAND 5'h1f
`define ASR_DB_SAMPLES 5'h10
`define ASR_FREQ_MIN_BASE 16'h0bb8
`define ASR_FREQ_MAX 16'h9c40
`define ASR_DEADBAND 16'h000a
`define ASR_ADC_FULL 12'hfff
`define ASR_PCT_FULL 7'h64
`define ASR_VOLT_FULL 16'h2710
// Timing
`define ASR_CLK_MHZ 125
`define ASR_SAMPLE_US 2000
`define ASR_TAU_MS 500
`define ASR_TAU_SAMPLES (`ASR_TAU_MS * 1000 / `ASR_SAMPLE_US)
`endif

/* File: verilog/asr_sample_mem.v */
`timescale 1ns/100ps
// Sample history for the moving average, registered read port
module asr_sample_mem #(
    parameter WIDTH = 16,
    parameter AW = 5
) (
    clock,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input wire clock;
    input wire wr_en;
    input wire [AW-1:0] wr_addr;
    input wire [WIDTH-1:0] wr_data;
    input wire [AW-1:0] rd_addr;
    output reg [WIDTH-1:0] rd_data;

    // Storage has no reset; the fill counter outside keeps stale words out
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Write and registered read share one edge
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* File: testbench/asr_top_asserts.sv */
`timescale 1ns/100ps
// Port-level checks of the speed reference block
module asr_top_asserts (
    input wire clock,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [15:0] freq_cmd,
    input wire [15:0] volt_cmd,
    input wire cmd_active
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // Address phases of reads and writes
    wire rd_req = hsel && hready && htrans[1] && !hwrite;
    wire wr_req = hsel && hready && htrans[1] && hwrite;
    // Control write whose data selects the terminal source or another one
    sequence src_on;
        wr_req && haddr[7:0] == 8'h00 ##1 hwdata[3:0] == 4'h1;
    endsequence
    sequence src_off;
        wr_req && haddr[7:0] == 8'h00 ##1 hwdata[3:0] != 4'h1;
    endsequence
    chk_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered with an error");
    chk_hrdata_hold: assert property (!rd_req |=> $stable(hrdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (rd_req && haddr[7:0] > 8'h20 |=> hrdata == 32'h0)
        else $error("unmapped read gave nonzero data");
    chk_status_view: assert property (rd_req && haddr[7:0] == 8'h1c |=>
        hrdata[15:0] == $past(freq_cmd) && hrdata[16] == $past(cmd_active))
        else $error("status word does not mirror the command outputs");
    chk_vout_view: assert property (rd_req && haddr[7:0] == 8'h20 |=>
        hrdata == {16'h0, $past(volt_cmd)})
        else $error("voltage word does not mirror the voltage output");
    chk_max_limit: assert property (freq_cmd <= 16'h9c40)
        else $error("frequency command above 400 Hz");
    chk_volt_scale: assert property (volt_cmd <= 16'h2710)
        else $error("voltage command above full scale");
    chk_zero_volt: assert property (freq_cmd == 16'h0 |=> volt_cmd == 16'h0)
        else $error("voltage without frequency");
    chk_idle_cmd: assert property (!cmd_active [*2] |-> freq_cmd == 16'h0)
        else $error("frequency command while source is not the terminal");
    chk_src_on: assert property (src_on |-> ##[1:3] cmd_active)
        else $error("terminal source selected but command not active");
    chk_src_off: assert property (src_off |-> ##[1:3] !cmd_active)
        else $error("other source selected but command still active");
endmodule

bind asr_top asr_top_asserts u_chk (.clock(clock), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .freq_cmd(freq_cmd),
    .volt_cmd(volt_cmd), .cmd_active(cmd_active));

/* File: testbench/asr_src_model.sv */
`timescale 1ns/100ps
// Far-side analog source: converted channel codes and the switch terminal
module asr_src_model (
    input logic clock,
    input logic nrst,
    input logic slow,
    input logic [11:0] set_volt,
    input logic [11:0] set_cur,
    input logic [11:0] set_pot,
    input logic set_sw,
    output logic [11:0] volt_in,
    output logic [11:0] cur_in,
    output logic [11:0] pot_in,
    output logic channel_switch_input
);
    logic [3:0] pace_reg; // Pace counter for the slow mode
    // Whole words change in one edge; slow mode only follows every 16th clock
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pace_reg <= 4'h0;
            volt_in <= 12'h000;
            cur_in <= 12'h000;
            pot_in <= 12'h000;
            channel_switch_input <= 1'b0;
        end else begin
            pace_reg <= pace_reg + 4'h1;
            if (!slow || pace_reg == 4'h0) begin
                // Code 0..4095 spans 0-10 V and 4-20 mA
                volt_in <= set_volt;
                cur_in <= set_cur;
                pot_in <= set_pot;
                channel_switch_input <= set_sw;
            end
        end
    end
endmodule

/* File: testbench/analog_speed_reference_test.sv */
`timescale 1ns/100ps
// Register and analog-path tests of the speed reference block
module analog_speed_reference_test;
    localparam SC = 64; // Short sample period keeps the run brief
    localparam LIMIT = 20000; // Ceiling well above the planned run
    logic clock, nrst, hsel, hwrite, hreadyout, hresp, set_sw, slow, cmd_active;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] set_volt, set_cur, set_pot, volt_in, cur_in, pot_in;
    logic channel_switch_input;
    logic [15:0] freq_cmd, volt_cmd;
    int error_cnt, compares, cyc, n;
    asr_top #(.SAMPLE_CYCLES(SC)) dut (.clock(clock), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .volt_in(volt_in), .cur_in(cur_in), .pot_in(pot_in),
        .channel_switch_input(channel_switch_input), .freq_cmd(freq_cmd),
        .volt_cmd(volt_cmd), .cmd_active(cmd_active));
    asr_src_model src (.clock(clock), .nrst(nrst), .slow(slow), .set_volt(set_volt),
        .set_cur(set_cur), .set_pot(set_pot), .set_sw(set_sw), .volt_in(volt_in),
        .cur_in(cur_in), .pot_in(pot_in), .channel_switch_input(channel_switch_input));
    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Cycle ceiling cuts a hung run short
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    // Counts, verdict and end of run
    task finish_test;
        begin
            $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // Compares one value and reports a mismatch at once
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One single AHB-Lite transfer; entered right after a rising edge
    task bus(input [7:0] a, input w, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            @(posedge clock);
            while (hreadyout !== 1'b1) @(posedge clock);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clock);
            while (hreadyout !== 1'b1) @(posedge clock);
            r = hrdata;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin
            bus(a, 1'b0, 32'h0);
            chk(r, e);
        end
    endtask
    // Applies source codes, lets four samples pass, checks both outputs
    task run(input [11:0] v, c, p, input s, input [15:0] f, u);
        begin
            set_volt <= v;
            set_cur <= c;
            set_pot <= p;
            set_sw <= s;
            repeat (4 * SC) @(posedge clock);
            @(negedge clock);
            chk({16'h0, freq_cmd}, {16'h0, f});
            chk({16'h0, volt_cmd}, {16'h0, u});
            @(posedge clock);
        end
    endtask
    // Main sequence
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        set_volt = 12'h0;
        set_cur = 12'h0;
        set_pot = 12'h0;
        set_sw = 1'b0;
        slow = 1'b0;
        error_cnt = 0;
        compares = 0;
        cyc = 0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk({15'h0, freq_cmd, cmd_active}, 32'h0);
        @(posedge clock);
        rchk(8'h00, 32'h0000_0842);
        rchk(8'h04, 32'h1770_1770);
        rchk(8'h08, 32'h1770_1770);
        rchk(8'h0c, 32'h0);
        rchk(8'h14, 32'h0);
        rchk(8'h10, 32'h0001_6400);
        rchk(8'h18, 32'h0001_6400);
        rchk(8'h24, 32'h0);
        wr(8'h1c, 32'hffff_ffff);
        rchk(8'h1c, 32'h0);
        // Motor 1 base 40 Hz max 60 Hz; voltage span 20..80 % onto 10..70 Hz
        wr(8'h04, 32'h1770_0fa0);
        wr(8'h08, 32'h0bb8_0bb8);
        wr(8'h0c, 32'h1b58_03e8);
        wr(8'h10, 32'h0000_5014);
        wr(8'h14, 32'h4e20_0000);
        wr(8'h00, 32'h0000_0141);
        rchk(8'h10, 32'h0000_5014);
        run(12'h000, 12'h0, 12'h0, 1'b0, 16'h03e8, 16'h09c4);
        run(12'h333, 12'h0, 12'h0, 1'b0, 16'h03e8, 16'h09c4);
        run(12'h999, 12'h0, 12'h0, 1'b0, 16'h1388, 16'h2710);
        run(12'hfff, 12'h0, 12'h0, 1'b0, 16'h1770, 16'h2710);
        wr(8'h10, 32'h0001_5014);
        run(12'h000, 12'h0, 12'h0, 1'b0, 16'h0000, 16'h0000);
        run(12'h000, 12'h333, 12'h0, 1'b1, 16'h0fa0, 16'h2710);
        wr(8'h00, 32'h0000_0161);
        run(12'h999, 12'h333, 12'h555, 1'b1, 16'h07d0, 16'h1388);
        run(12'h999, 12'h333, 12'h555, 1'b0, 16'h1388, 16'h2710);
        wr(8'h00, 32'h0000_0171);
        run(12'h999, 12'h333, 12'h555, 1'b1, 16'h07d0, 16'h1388);
        run(12'h999, 12'h333, 12'h555, 1'b0, 16'h0fa0, 16'h2710);
        wr(8'h00, 32'h0000_0101);
        run(12'h333, 12'h333, 12'h555, 1'b0, 16'h1388, 16'h2710);
        wr(8'h00, 32'h0000_01c1);
        run(12'h999, 12'h0, 12'h0, 1'b0, 16'h0bb8, 16'h2710);
        // Motor 2 settings: out-of-range base rises to 30 Hz, max set at the 400 Hz limit
        wr(8'h08, 32'h9c40_0064);
        slow <= 1'b1;
        run(12'h333, 12'h0, 12'h0, 1'b0, 16'h03e8, 16'h0d05);
        rchk(8'h20, 32'h0000_0d05);
        rchk(8'h1c, 32'h0001_03e8);
        run(12'hfff, 12'h0, 12'h0, 1'b0, 16'h1b58, 16'h2710);
        slow <= 1'b0;
        wr(8'h00, 32'h0000_01c2);
        run(12'hfff, 12'h0, 12'h0, 1'b0, 16'h0000, 16'h0000);
        rchk(8'h1c, 32'h0);
        // Two-sample average: switch step gives the mean of the two channels
        wr(8'h00, 32'h0000_0241);
        wr(8'h10, 32'h0000_5014);
        run(12'h000, 12'h333, 12'h0, 1'b0, 16'h03e8, 16'h09c4);
        set_sw <= 1'b1;
        n = 0;
        @(negedge clock);
        while (freq_cmd === 16'h03e8 && n < 3 * SC) begin
            @(negedge clock);
            n = n + 1;
        end
        chk({16'h0, freq_cmd}, 32'h0000_09c4);
        @(posedge clock);
        // Deadband mode: slow filter, output moves only past 0.1 Hz
        wr(8'h00, 32'h0000_1f41);
        // Step down to 10 Hz: the slow filter must still lag well above it
        set_sw <= 1'b0;
        repeat (40 * SC) @(posedge clock);
        bus(8'h1c, 1'b0, 32'h0);
        chk({31'h0, r[17]}, 32'h1);
        @(negedge clock);
        chk({31'h0, freq_cmd > 16'h03e8 && freq_cmd < 16'h0fa0}, 32'h1);
        finish_test;
    end
endmodule
